// *** iox_regbank.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-wire bus slave and register bank of a 16-bit I/O expander.
// Assumes: Bus and pins are slow against the 10 MHz core clock.
// Notes: Pins are split into input, output and output enable.
//
// Summary of operation
// - Answer address 010000 plus strap level as lowest of seven bits.
// - Last address bit one means read, zero means write.
// - First byte after an acknowledged write address loads the pointer.
// - Pointer is set by the command byte, bit 0 flips after each written or acknowledged read byte; never read back.
// - Pointer bits 3 to 0 pick the register, bit 6 the group.
// - Codes 00-01 input read-only; 02-03 output, 06-07 direction reset ones.
// - Codes 04-05 polarity inversion bytes, read/write, reset to zero.
// - Codes 4A-4B interrupt mask bytes, reset all ones.
// - Codes 4C-4D interrupt status bytes, read-only, reset to zero.
// - Code 4F output-type byte, read/write, reset to zero.
// - Codes 44-45 input latch enable bytes, reset to zero.
// - Input bytes show pin levels for any direction; writes ignored.
// - Direction bit one makes the pin an input, zero an output.
// - Polarity bit one inverts the pin level seen in input byte.
// - Two bits per pin set drive: quarter, half, three quarters, full.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module iox_regbank (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_strap_i,
  input wire logic [15:0] port_pin_i,
  output logic [15:0] port_pin_o,
  output logic [15:0] port_pin_oe_o,
  output logic [31:0] drive_level_field_o,
  output logic [15:0] pull_enable_o,
  output logic [15:0] pull_select_o,
  output logic [1:0] open_drain_o,
  output logic [15:0] irq_flags_o
);
  import iox_pkg::*;

  typedef struct packed {
    iox_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic sda_drv;
    logic [7:0] ptr;
    logic scl_q;
    logic sda_q;
    logic [15:0] out;
    logic [15:0] inv;
    logic [15:0] dir;
    logic [31:0] drv;
    logic [15:0] lat;
    logic [15:0] pen;
    logic [15:0] psel;
    logic [15:0] msk;
    logic [15:0] flg;
    logic [7:0] otype;
    logic [15:0] held;
    logic [15:0] hold;
    logic [15:0] last_in;
  } iox_state_s;

  localparam iox_state_s RST_STATE = '{
    st: ST_IDLE, cnt: 4'h0, sh: 8'h00, rw: 1'b0, nack: 1'b0,
    sda_drv: 1'b0, ptr: PTR_IN0, scl_q: 1'b1, sda_q: 1'b1,
    out: RST_OUT, inv: RST_INV, dir: RST_DIR, drv: RST_DRV,
    lat: RST_LAT, pen: RST_PEN, psel: RST_PSEL, msk: RST_MSK,
    flg: RST_FLG, otype: RST_OTYPE, held: 16'h0000, hold: 16'h0000,
    last_in: 16'h0000};

  iox_state_s r;
  iox_state_s n;

  logic [1:0] bus_f;
  logic [16:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic strap_f;
  logic [15:0] pin_f;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic byte_done;
  logic addr_hit;
  logic load_ev;
  logic [7:0] load_ptr;
  logic [15:0] rd_clr;
  logic [15:0] chg;
  logic [15:0] cap;
  logic [15:0] in_view;
  logic [7:0] rd_data;
  logic [3:0] wsel;
  logic [4:0] dsel;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  iox_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .d_i({scl_i, sda_i}),
    .q_o(bus_f)
  );

  iox_sync #(.W(17), .INIT(17'h00000)) u_pin_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .d_i({addr_strap_i, port_pin_i}),
    .q_o(pins_f)
  );

  assign scl_f = bus_f[1];
  assign sda_f = bus_f[0];
  assign strap_f = pins_f[16];
  assign pin_f = pins_f[15:0];

  //////////////////////////////////////////////////////////////////////////
  // Bus events and pin view.

  assign rise = scl_f & ~r.scl_q;
  assign fall = ~scl_f & r.scl_q;
  assign start_ev = scl_f & r.scl_q & r.sda_q & ~sda_f;
  assign stop_ev = scl_f & r.scl_q & ~r.sda_q & sda_f;
  assign byte_done = fall && (r.cnt == BITS_PER_BYTE);
  assign addr_hit = (r.sh[7:1] == {IOX_ADDR_HI, strap_f});
  assign load_ev = fall && ((r.st == ST_ACK_ADDR && r.rw) ||
                            (r.st == ST_MACK && !r.nack));
  assign load_ptr = (r.st == ST_MACK) ? {r.ptr[7:1], ~r.ptr[0]} : r.ptr;
  assign rd_clr = !load_ev ? 16'h0000 :
                  (load_ptr == PTR_IN0) ? CLR_PORT0 :
                  (load_ptr == PTR_IN1) ? CLR_PORT1 : 16'h0000;
  assign chg = pin_f ^ r.last_in;
  assign cap = r.lat & chg & ~r.held;
  // Pin level for any direction, latched copy when enabled.
  assign in_view = ((r.hold & r.lat & r.held) |
                    (pin_f & ~(r.lat & r.held))) ^ r.inv;
  assign wsel = {r.ptr[0], 3'h0};
  assign dsel = {r.ptr[1:0], 3'h0};

  always_comb begin
    rd_data = RD_NONE;
    case (load_ptr)
      PTR_IN0: rd_data = in_view[7:0];
      PTR_IN1: rd_data = in_view[15:8];
      PTR_OUT0: rd_data = r.out[7:0];
      PTR_OUT1: rd_data = r.out[15:8];
      PTR_INV0: rd_data = r.inv[7:0];
      PTR_INV1: rd_data = r.inv[15:8];
      PTR_DIR0: rd_data = r.dir[7:0];
      PTR_DIR1: rd_data = r.dir[15:8];
      PTR_DRV0L: rd_data = r.drv[7:0];
      PTR_DRV0H: rd_data = r.drv[15:8];
      PTR_DRV1L: rd_data = r.drv[23:16];
      PTR_DRV1H: rd_data = r.drv[31:24];
      PTR_LAT0: rd_data = r.lat[7:0];
      PTR_LAT1: rd_data = r.lat[15:8];
      PTR_PEN0: rd_data = r.pen[7:0];
      PTR_PEN1: rd_data = r.pen[15:8];
      PTR_PSEL0: rd_data = r.psel[7:0];
      PTR_PSEL1: rd_data = r.psel[15:8];
      PTR_MSK0: rd_data = r.msk[7:0];
      PTR_MSK1: rd_data = r.msk[15:8];
      PTR_FLG0: rd_data = r.flg[7:0];
      PTR_FLG1: rd_data = r.flg[15:8];
      PTR_OTYPE: rd_data = r.otype;
      default: rd_data = RD_NONE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    n = r;
    n.scl_q = scl_f;
    n.sda_q = sda_f;
    n.last_in = pin_f;
    // An unmasked change sets its flag even while a read clears it.
    n.held = (r.held & ~rd_clr) | cap;
    n.hold = (r.hold & ~cap) | (pin_f & cap);
    n.flg = (r.flg & ~rd_clr) | (chg & ~r.msk);
    case (r.st)
      ST_IDLE: begin
        n.sda_drv = 1'b0;
      end
      ST_ADDR, ST_CMD, ST_WDATA: begin
        if (rise) begin
          n.sh = {r.sh[6:0], sda_f};
          n.cnt = r.cnt + 4'h1;
        end else if (byte_done) begin
          n.cnt = 4'h0;
          n.sda_drv = 1'b1;
          n.st = ST_ACK_W;
          if (r.st == ST_ADDR) begin
            if (addr_hit) begin
              n.rw = r.sh[0];
              n.st = ST_ACK_ADDR;
            end else begin
              n.sda_drv = 1'b0;
              n.st = ST_IDLE;
            end
          end else if (r.st == ST_CMD) begin
            n.ptr = r.sh;
          end else begin
            n.ptr = {r.ptr[7:1], ~r.ptr[0]};
            case (r.ptr)
              PTR_OUT0, PTR_OUT1: n.out[wsel +: 8] = r.sh;
              PTR_INV0, PTR_INV1: n.inv[wsel +: 8] = r.sh;
              PTR_DIR0, PTR_DIR1: n.dir[wsel +: 8] = r.sh;
              PTR_DRV0L, PTR_DRV0H, PTR_DRV1L, PTR_DRV1H:
                n.drv[dsel +: 8] = r.sh;
              PTR_LAT0, PTR_LAT1: n.lat[wsel +: 8] = r.sh;
              PTR_PEN0, PTR_PEN1: n.pen[wsel +: 8] = r.sh;
              PTR_PSEL0, PTR_PSEL1: n.psel[wsel +: 8] = r.sh;
              PTR_MSK0, PTR_MSK1: n.msk[wsel +: 8] = r.sh;
              PTR_OTYPE: n.otype = r.sh;
              default: n.ptr = {r.ptr[7:1], ~r.ptr[0]};
            endcase
          end
        end
      end
      ST_ACK_ADDR: begin
        if (fall) begin
          if (r.rw) begin
            n.sh = rd_data;
            n.sda_drv = ~rd_data[7];
            n.st = ST_RDATA;
          end else begin
            n.sda_drv = 1'b0;
            n.st = ST_CMD;
          end
        end
      end
      ST_ACK_W: begin
        if (fall) begin
          n.sda_drv = 1'b0;
          n.st = ST_WDATA;
        end
      end
      ST_RDATA: begin
        if (fall) begin
          n.cnt = r.cnt + 4'h1;
          n.sh = {r.sh[6:0], 1'b0};
          n.sda_drv = ~r.sh[6];
          if (r.cnt == BITS_PER_BYTE - 4'h1) begin
            n.cnt = 4'h0;
            n.sda_drv = 1'b0;
            n.st = ST_MACK;
          end
        end
      end
      ST_MACK: begin
        if (rise) begin
          n.nack = sda_f;
        end else if (fall) begin
          if (r.nack) begin
            n.st = ST_IDLE;
          end else begin
            n.ptr = load_ptr;
            n.sh = rd_data;
            n.sda_drv = ~rd_data[7];
            n.st = ST_RDATA;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (start_ev) begin
      n.st = ST_ADDR;
      n.cnt = 4'h0;
      n.sda_drv = 1'b0;
    end else if (stop_ev) begin
      n.st = ST_IDLE;
      n.sda_drv = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      r <= RST_STATE;
    end else begin
      r <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign sda_o = 1'b0;
  assign sda_oe_o = r.sda_drv;
  assign port_pin_o = r.out;
  // A high output bit on an open-drain port releases the pin.
  assign port_pin_oe_o = ~r.dir & ~(r.out & {{8{r.otype[OTYPE_PORT1]}},
                                   {8{r.otype[OTYPE_PORT0]}}});
  assign drive_level_field_o = r.drv;
  assign pull_enable_o = r.pen;
  assign pull_select_o = r.psel;
  assign open_drain_o = r.otype[1:0];
  assign irq_flags_o = r.flg;

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_addr_end;
    r.st == ST_ADDR && byte_done;
  endsequence

  sequence s_cmd_end;
    r.st == ST_CMD && byte_done;
  endsequence

  property p_addr_hit;
    @(posedge clock_i) disable iff (!rstn_i)
    s_addr_end and (addr_hit && !start_ev && !stop_ev) |=>
      r.st == ST_ACK_ADDR && sda_oe_o;
  endproperty
  a_addr_hit: assert property (p_addr_hit)
    else $error("Own address not acknowledged.");

  property p_addr_miss;
    @(posedge clock_i) disable iff (!rstn_i)
    s_addr_end and (!addr_hit && !start_ev) |=> r.st == ST_IDLE && !sda_oe_o;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("Foreign address acknowledged.");

  property p_rw_dir;
    @(posedge clock_i) disable iff (!rstn_i)
    s_addr_end and (addr_hit && !start_ev && !stop_ev) |=>
      r.rw == $past(r.sh[0]);
  endproperty
  a_rw_dir: assert property (p_rw_dir)
    else $error("Transfer direction not taken from last address bit.");

  property p_cmd_load;
    @(posedge clock_i) disable iff (!rstn_i)
    s_cmd_end and (!start_ev && !stop_ev) |=> r.ptr == $past(r.sh);
  endproperty
  a_cmd_load: assert property (p_cmd_load)
    else $error("Command byte not stored in pointer.");

  property p_ptr_read_hold;
    @(posedge clock_i) disable iff (!rstn_i)
    r.st == ST_RDATA |=> $stable(r.ptr);
  endproperty
  a_ptr_read_hold: assert property (p_ptr_read_hold)
    else $error("Pointer changed while a byte was read.");

  property p_reset_vals;
    @(posedge clock_i)
    !rstn_i |=> r.msk == RST_MSK && r.flg == RST_FLG &&
      r.otype == RST_OTYPE && r.lat == RST_LAT && r.inv == RST_INV &&
      r.out == RST_OUT && r.dir == RST_DIR;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Register reset value wrong.");

  property p_dir_in;
    @(posedge clock_i) disable iff (!rstn_i)
    (r.dir & port_pin_oe_o) == 16'h0000;
  endproperty
  a_dir_in: assert property (p_dir_in)
    else $error("Pin driven while set as input.");

  property p_invert;
    @(posedge clock_i) disable iff (!rstn_i)
    r.lat == 16'h0000 |-> in_view == (pin_f ^ r.inv);
  endproperty
  a_invert: assert property (p_invert)
    else $error("Input view does not follow pins and inversion.");

  property p_ignored_write;
    @(posedge clock_i) disable iff (!rstn_i)
    r.st == ST_WDATA && byte_done &&
      (r.ptr == PTR_IN0 || r.ptr == PTR_FLG0 || r.ptr == 8'h4e) |=>
      $stable(r.out) && $stable(r.dir) && $stable(r.msk) &&
      $stable(r.otype) && $stable(r.inv);
  endproperty
  a_ignored_write: assert property (p_ignored_write)
    else $error("Write to a read-only or unmapped code changed a register.");

  property p_drive;
    @(posedge clock_i) disable iff (!rstn_i)
    r.st == ST_WDATA && byte_done && !start_ev && !stop_ev &&
      r.ptr == PTR_DRV0H |=> drive_level_field_o[15:8] == $past(r.sh);
  endproperty
  a_drive: assert property (p_drive)
    else $error("Drive level byte not written.");

endmodule // iox_regbank

// *** iox_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants for the 16-bit I/O expander register bank.
// Assumes: Two-wire bus pins sampled by the core clock.
// Notes: Pointer codes, reset values and the bus address prefix.
//////////////////////////////////////////////////////////////////////////////
package iox_pkg;

  localparam logic [5:0] IOX_ADDR_HI = 6'h10;

  localparam logic [7:0] PTR_IN0 = 8'h00;
  localparam logic [7:0] PTR_IN1 = 8'h01;
  localparam logic [7:0] PTR_OUT0 = 8'h02;
  localparam logic [7:0] PTR_OUT1 = 8'h03;
  localparam logic [7:0] PTR_INV0 = 8'h04;
  localparam logic [7:0] PTR_INV1 = 8'h05;
  localparam logic [7:0] PTR_DIR0 = 8'h06;
  localparam logic [7:0] PTR_DIR1 = 8'h07;
  localparam logic [7:0] PTR_DRV0L = 8'h40;
  localparam logic [7:0] PTR_DRV0H = 8'h41;
  localparam logic [7:0] PTR_DRV1L = 8'h42;
  localparam logic [7:0] PTR_DRV1H = 8'h43;
  localparam logic [7:0] PTR_LAT0 = 8'h44;
  localparam logic [7:0] PTR_LAT1 = 8'h45;
  localparam logic [7:0] PTR_PEN0 = 8'h46;
  localparam logic [7:0] PTR_PEN1 = 8'h47;
  localparam logic [7:0] PTR_PSEL0 = 8'h48;
  localparam logic [7:0] PTR_PSEL1 = 8'h49;
  localparam logic [7:0] PTR_MSK0 = 8'h4a;
  localparam logic [7:0] PTR_MSK1 = 8'h4b;
  localparam logic [7:0] PTR_FLG0 = 8'h4c;
  localparam logic [7:0] PTR_FLG1 = 8'h4d;
  localparam logic [7:0] PTR_OTYPE = 8'h4f;

  localparam logic [15:0] RST_OUT = 16'hffff;
  localparam logic [15:0] RST_INV = 16'h0000;
  localparam logic [15:0] RST_DIR = 16'hffff;
  localparam logic [31:0] RST_DRV = 32'hffff_ffff;
  localparam logic [15:0] RST_LAT = 16'h0000;
  localparam logic [15:0] RST_PEN = 16'h0000;
  localparam logic [15:0] RST_PSEL = 16'hffff;
  localparam logic [15:0] RST_MSK = 16'hffff;
  localparam logic [15:0] RST_FLG = 16'h0000;
  localparam logic [7:0] RST_OTYPE = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;

  localparam logic [15:0] CLR_PORT0 = 16'h00ff;
  localparam logic [15:0] CLR_PORT1 = 16'hff00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int OTYPE_PORT0 = 0;
  localparam int OTYPE_PORT1 = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK_ADDR = 3'h2,
    ST_CMD = 3'h3,
    ST_WDATA = 3'h4,
    ST_ACK_W = 3'h5,
    ST_RDATA = 3'h6,
    ST_MACK = 3'h7
  } iox_state_e;

endpackage

// *** iox_sync.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Inputs come from outside the clock domain.
// Notes: Output follows once stages two and three agree.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module iox_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } iox_sync_s;

  iox_sync_s r;
  iox_sync_s n;

  always_comb begin
    n = r;
    n.s1 = d_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      r <= {INIT, INIT, INIT, INIT};
    end else begin
      r <= n;
    end
  end

  assign q_o = r.q;
endmodule // iox_sync

// *** iox_bus_master.sv ***
////////////////////////////////////////
// Purpose: Two-wire bus master model for the expander bench.
// Assumes: Each SCL phase lasts at least four core clocks.
// Notes: Open drain; SDA is released unless a zero is sent.
`timescale 1ns/100ps
module iox_bus_master (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // One bit; data changes only while SCL is low.
  task automatic bit_x(input logic b, output logic r);
    sda_oe_o = ~b;
    wt(4);
    scl_o = 1'b1;
    wt(4);
    r = sda_i;
    wt(4);
    scl_o = 1'b0;
    wt(4);
  endtask
  // Start or repeated start: SDA falls while SCL is high.
  task automatic start();
    sda_oe_o = 1'b0;
    wt(4);
    scl_o = 1'b1;
    wt(8);
    sda_oe_o = 1'b1;
    wt(8);
    scl_o = 1'b0;
    wt(4);
  endtask
  // Stop: SDA rises while SCL is high, then the clock stands still.
  task automatic stop();
    sda_oe_o = 1'b1;
    wt(4);
    scl_o = 1'b1;
    wt(8);
    sda_oe_o = 1'b0;
    wt(8);
  endtask
  // Sends a byte; ack is high when the slave pulled SDA low.
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Takes a byte; last sends a NACK, otherwise an ACK continues.
  task automatic rd(input logic last);
    logic [7:0] v;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      v[i] = r;
    end
    bit_x(last, r);
    rd_data_o = v;
    rd_valid_o = 1'b1;
    wt(1);
    rd_valid_o = 1'b0;
  endtask
endmodule // iox_bus_master

// *** test_io_expander_pointer_register_map.sv ***
////////////////////////////////////////
// Purpose: Self-checking bench for the expander register bank.
// Assumes: The master model owns SCL and shares SDA with a pull-up.
// Notes: Read bytes are checked against a queue of expected values.
`timescale 1ns/100ps
module test_io_expander_pointer_register_map;
  import iox_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic strap = 1'b0;
  logic pad_on = 1'b0;
  logic [15:0] ext = 16'h5a3c;
  logic [15:0] flg_e = 16'h0000;
  logic [31:0] rs = 32'ha02d72dd;
  logic [7:0] sh [0:127];
  logic [7:0] exp_q [$];
  int err_count = 0;
  int check_count = 0;
  logic scl, m_oe, sda_o, sda_oe, rd_v, sda;
  logic [7:0] rd_d;
  logic [15:0] pin_o, pin_oe, pen, psel, flags, pins;
  logic [31:0] drv;
  logic [1:0] od;
  always #50 clock = ~clock;
  assign sda = ~m_oe & (~pad_on | ~sda_oe | sda_o);
  assign pins = pad_on ? ((pin_o & pin_oe) | (ext & ~pin_oe)) : ext;
  iox_regbank dut (.clock_i(clock), .rstn_i(rstn), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_strap_i(strap),
    .port_pin_i(pins), .port_pin_o(pin_o), .port_pin_oe_o(pin_oe),
    .drive_level_field_o(drv), .pull_enable_o(pen),
    .pull_select_o(psel), .open_drain_o(od), .irq_flags_o(flags));
  iox_bus_master m (.clock_i(clock), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(m_oe), .rd_valid_o(rd_v), .rd_data_o(rd_d));
  function automatic logic [15:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs[15:0];
  endfunction
  function automatic logic is_rw(input logic [7:0] p);
    return p inside {[8'h02:8'h07], [8'h40:8'h4b], 8'h4f};
  endfunction
  function automatic logic [15:0] oe_e();
    logic [15:0] odm;
    odm = {{8{sh[7'h4f][1]}}, {8{sh[7'h4f][0]}}};
    return ~{sh[7], sh[6]} & ~(odm & {sh[3], sh[2]});
  endfunction
  function automatic logic [7:0] exp_b(input logic [7:0] p);
    logic [15:0] v;
    v = (({sh[3], sh[2]} & oe_e()) | (ext & ~oe_e())) ^ {sh[5], sh[4]};
    case (p)
      8'h00: return v[7:0];
      8'h01: return v[15:8];
      8'h4c: return flg_e[7:0];
      8'h4d: return flg_e[15:8];
      default: return is_rw(p) ? sh[p[6:0]] : RD_NONE;
    endcase
  endfunction
  task automatic chk_vec(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    if (rd_v === 1'b1) chk_byte("read", exp_q.pop_front(), rd_d);
  end
  task automatic do_reset();
    rstn = 1'b0;
    flg_e = 16'h0000;
    for (int i = 0; i < 128; i++)
      sh[i] = (i inside {[2:3], [6:7], [64:67], [72:75]}) ? 8'hff : 8'h00;
    repeat (6) @(negedge clock);
    pad_on = 1'b1;
    rstn = 1'b1;
    repeat (8) @(negedge clock);
  endtask
  task automatic chk_ports();
    chk_vec("out", 32'({sh[3], sh[2]}), 32'(pin_o));
    chk_vec("oe", 32'(oe_e()), 32'(pin_oe));
    chk_vec("drv", {sh[67], sh[66], sh[65], sh[64]}, drv);
    chk_vec("pen", 32'({sh[71], sh[70]}), 32'(pen));
    chk_vec("psel", 32'({sh[73], sh[72]}), 32'(psel));
    chk_vec("od", 32'(sh[79][1:0]), 32'(od));
  endtask
  task automatic tx_w(input logic [7:0] p, input int n, input logic [15:0] d);
    logic a;
    m.start();
    m.wr({IOX_ADDR_HI, strap, 1'b0}, a);
    chk_vec("ack", 32'h1, 32'(a));
    m.wr(p, a);
    for (int i = 0; i < n; i++) begin
      m.wr(d[8*i +: 8], a);
      if (is_rw(p)) sh[p[6:0]] = d[8*i +: 8];
      p[0] = ~p[0];
    end
    m.stop();
  endtask
  task automatic tx_r(input logic [7:0] p, input int n, input logic set_p);
    logic a;
    if (set_p) begin
      m.start();
      m.wr({IOX_ADDR_HI, strap, 1'b0}, a);
      m.wr(p, a);
    end
    m.start();
    m.wr({IOX_ADDR_HI, strap, 1'b1}, a);
    chk_vec("ack", 32'h1, 32'(a));
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(exp_b(p));
      m.rd(i == n - 1);
      p[0] = ~p[0];
    end
    m.stop();
  endtask
  initial begin
    do_reset();
    chk_ports();
    chk_vec("flags", 32'h0, 32'(flags));
    for (int i = 0; i < 24; i++)
      tx_r(8'((i < 8) ? i : 56 + i), 1, 1'b1);
    for (int k = 1; k < 10; k++)
      tx_w(8'((k < 4) ? 2 * k : 56 + 2 * k), 2, rnd());
    tx_w(8'h4f, 1, rnd());
    repeat (8) @(negedge clock);
    chk_ports();
    for (int k = 1; k < 10; k++)
      tx_r(8'((k < 4) ? 2 * k : 56 + 2 * k), 2, 1'b1);
    tx_r(8'h4f, 1, 1'b1);
    do_reset();
    ext = rnd();
    tx_w(8'h04, 2, rnd());
    tx_w(8'h06, 2, 16'hff00);
    tx_w(8'h02, 2, rnd());
    tx_r(8'h00, 2, 1'b1);
    tx_w(8'h4f, 1, 16'h0001);
    tx_w(8'h00, 2, rnd());
    tx_w(8'h4c, 2, rnd());
    tx_r(8'h00, 2, 1'b1);
    tx_r(8'h4c, 2, 1'b1);
    chk_ports();
    tx_w(8'h04, 0, 16'h0000);
    tx_r(8'h04, 1, 1'b0);
    do_reset();
    tx_w(8'h4a, 2, 16'hfffe);
    ext = ext ^ 16'h0003;
    flg_e = 16'h0001;
    repeat (10) @(negedge clock);
    chk_vec("flags", 32'(flg_e), 32'(flags));
    tx_r(8'h4c, 2, 1'b1);
    tx_r(8'h00, 1, 1'b1);
    flg_e = 16'h0000;
    repeat (10) @(negedge clock);
    chk_vec("flags", 32'h0, 32'(flags));
    for (int s = 0; s < 2; s++) begin
      logic a;
      strap = s[0];
      repeat (10) @(negedge clock);
      m.start();
      m.wr({IOX_ADDR_HI, ~strap, 1'b0}, a);
      chk_vec("nack", 32'h0, 32'(a));
      m.stop();
      tx_r(8'h4b, 1, 1'b1);
    end
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    report_and_stop();
  end
endmodule // test_io_expander_pointer_register_map
